// ==== rtl/fws_defs.svh ====
// Constants for the flash status poller: bit positions, commands and timing counts
`ifndef FWS_DEFS_SVH
`define FWS_DEFS_SVH

`define FWS_ADDR_W          22
`define FWS_DATA_W          16
`define FWS_BIT_POLL        7
`define FWS_BIT_TOGGLE      6
`define FWS_BIT_LIMIT       5
`define FWS_BIT_SECTOR      2
`define FWS_CMD_RESET       16'h00F0
`define FWS_CLK_MHZ         100
`define FWS_STROBE_NS       70
`define FWS_STROBE_CYC      ((`FWS_STROBE_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_GAP_NS          30
`define FWS_GAP_CYC         ((`FWS_GAP_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_TIMEOUT_US      200000
`define FWS_TIMEOUT_CYC     (`FWS_TIMEOUT_US * `FWS_CLK_MHZ)
`define FWS_REG_CTRL        4'h0
`define FWS_REG_ADDR        4'h1
`define FWS_REG_DATA        4'h2
`define FWS_REG_STATUS      4'h3
`define FWS_REG_WORD        4'h4
`define FWS_ST_BUSY         0
`define FWS_ST_DONE         1
`define FWS_ST_FAIL         2
`define FWS_ST_TMO          3
`define FWS_ST_RDY          4
`define FWS_ST_SECT         5

`endif

// ==== rtl/fws_pkg.sv ====
// Types for the flash status poller
package fws_pkg;
    typedef enum logic [0:0] {
        FWS_MODE_POLL,
        FWS_MODE_TOGGLE
    } fws_mode_t;

    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } fws_bus_t;
endpackage

// ==== rtl/fws_poller.sv ====
// Host-side status poller for an asynchronous NOR flash program or erase
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "fws_defs.svh"

module fws_poller #(
    parameter int unsigned ADDR_W      = `FWS_ADDR_W,
    parameter int unsigned DATA_W      = `FWS_DATA_W,
    parameter int unsigned STROBE_CYC  = `FWS_STROBE_CYC,
    parameter int unsigned GAP_CYC     = `FWS_GAP_CYC,
    parameter int unsigned TIMEOUT_CYC = `FWS_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [31:0]       reg_rdata,
    // Flash strobes, active low, and address
    output logic                   flash_ce_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic      [ADDR_W-1:0] flash_addr,
    // Flash data bus, three signals
    input  wire logic [DATA_W-1:0] data_bus_in,
    output logic      [DATA_W-1:0] data_bus_out,
    output logic                   data_bus_oe,
    // Ready/busy pin, open drain pulled up outside
    input  wire logic              ready_busy_output
);

    typedef enum logic [2:0] {
        S_IDLE, S_READ, S_GAP, S_EVAL, S_RESET, S_DONE
    } fws_state_t;

    fws_state_t        state_r;
    fws_pkg::fws_mode_t mode_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0]        expect_r;
    logic              erase_r;
    logic [15:0]       cnt_r;
    logic [31:0]       tmo_r;
    logic [DATA_W-1:0] word_r;
    logic [DATA_W-1:0] prev_r;
    logic [1:0]        nreads_r;
    logic              limit_seen_r;
    logic              busy_r;
    logic              done_r;
    logic              fail_r;
    logic              tmo_flag_r;
    logic              sect_r;
    logic              start;
    logic              poll_true;
    logic              tog_same;

    // Bit 7 target: program data bit 7, or 1 for erase
    assign poll_true = word_r[`FWS_BIT_POLL] == (erase_r ? 1'b1 : expect_r[7]);
    assign tog_same  = word_r[`FWS_BIT_TOGGLE] == prev_r[`FWS_BIT_TOGGLE];
    assign start     = reg_we && reg_addr == `FWS_REG_CTRL && reg_wdata[0] && !busy_r;

    // Register writes: target address, expected data byte, erase and mode bits
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_r   <= '0;
            expect_r <= 8'h00;
            erase_r  <= 1'b0;
            mode_r   <= fws_pkg::FWS_MODE_POLL;
        end else if (reg_we && !busy_r) begin
            if (reg_addr == `FWS_REG_ADDR) begin
                addr_r <= reg_wdata[ADDR_W-1:0];
            end
            if (reg_addr == `FWS_REG_DATA) begin
                expect_r <= reg_wdata[7:0];
            end
            if (reg_addr == `FWS_REG_CTRL) begin
                erase_r <= reg_wdata[1];
                mode_r  <= reg_wdata[2] ? fws_pkg::FWS_MODE_TOGGLE : fws_pkg::FWS_MODE_POLL;
            end
        end
    end

    // Read data one cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_re) begin
            unique case (reg_addr)
                `FWS_REG_CTRL:   reg_rdata <= {29'h0, mode_r, erase_r, busy_r};
                `FWS_REG_ADDR:   reg_rdata <= {{(32-ADDR_W){1'b0}}, addr_r};
                `FWS_REG_DATA:   reg_rdata <= {24'h0, expect_r};
                `FWS_REG_STATUS: reg_rdata <= {26'h0, sect_r, ready_busy_output, tmo_flag_r,
                                               fail_r, done_r, busy_r};
                `FWS_REG_WORD:   reg_rdata <= {{(32-DATA_W){1'b0}}, word_r};
                default:         reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Sequencer: read cycles, compare, decide, reset on failure
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r      <= S_IDLE;
            cnt_r        <= 16'h0000;
            tmo_r        <= 32'h0000_0000;
            word_r       <= '0;
            prev_r       <= '0;
            nreads_r     <= 2'd0;
            limit_seen_r <= 1'b0;
            busy_r       <= 1'b0;
            done_r       <= 1'b0;
            fail_r       <= 1'b0;
            tmo_flag_r   <= 1'b0;
            sect_r       <= 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (start) begin
                        // Software starts only after its last command write
                        state_r      <= S_READ;
                        busy_r       <= 1'b1;
                        done_r       <= 1'b0;
                        fail_r       <= 1'b0;
                        tmo_flag_r   <= 1'b0;
                        nreads_r     <= 2'd0; // Fresh double read each start
                        limit_seen_r <= 1'b0;
                        tmo_r        <= 32'h0000_0000;
                        cnt_r        <= 16'h0000;
                    end
                end
                S_READ: begin
                    cnt_r <= cnt_r + 16'h0001;
                    tmo_r <= tmo_r + 32'h0000_0001;
                    if (cnt_r == 16'(STROBE_CYC - 1)) begin
                        // Each read is a separate strobe so toggle bits advance
                        prev_r  <= word_r;
                        word_r  <= data_bus_in;
                        cnt_r   <= 16'h0000;
                        state_r <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    state_r <= S_GAP;
                    if (nreads_r != 2'd3) begin
                        nreads_r <= nreads_r + 2'd1;
                    end
                    if (prev_r[`FWS_BIT_SECTOR] != word_r[`FWS_BIT_SECTOR] && nreads_r != 2'd0) begin
                        sect_r <= 1'b1; // Sector selected for erase
                    end
                    if (mode_r == fws_pkg::FWS_MODE_POLL) begin
                        // A match after the limit flag is a success as well, so done is set on every
                        // path from a match to S_DONE; the path through S_RESET clears it
                        if (poll_true && done_r) begin
                            state_r <= S_DONE; // Word taken after the switch
                        end else if (poll_true) begin
                            done_r <= 1'b1; // Full word retaken on a later read
                        end else if (limit_seen_r && !done_r) begin
                            state_r <= S_RESET; // Recheck after limit failed
                        end else if (word_r[`FWS_BIT_LIMIT]) begin
                            limit_seen_r <= 1'b1; // Reread once more
                        end
                    end else if (nreads_r != 2'd0) begin
                        if (tog_same) begin
                            state_r <= S_DONE; // Next read cycle gives array data
                            done_r  <= 1'b1;
                        end else if (limit_seen_r) begin
                            state_r <= S_RESET; // Still toggling after limit
                        end else if (word_r[`FWS_BIT_LIMIT]) begin
                            limit_seen_r <= 1'b1;
                        end
                    end
                    if (tmo_r >= TIMEOUT_CYC) begin
                        state_r    <= S_RESET;
                        tmo_flag_r <= 1'b1;
                    end
                end
                S_GAP: begin
                    cnt_r <= cnt_r + 16'h0001;
                    tmo_r <= tmo_r + 32'h0000_0001;
                    if (cnt_r == 16'(GAP_CYC - 1)) begin
                        cnt_r   <= 16'h0000;
                        state_r <= S_READ;
                    end
                end
                S_RESET: begin
                    // Reset write over STROBE_CYC cycles, write strobe low for all but the last, any address
                    cnt_r <= cnt_r + 16'h0001;
                    if (cnt_r == 16'(STROBE_CYC - 1)) begin
                        cnt_r   <= 16'h0000;
                        fail_r  <= 1'b1;
                        done_r  <= 1'b0;
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy_r  <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Pins: strobes from state, reset word driven only while writing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flash_ce_n   <= 1'b1;
            flash_oe_n   <= 1'b1;
            flash_we_n   <= 1'b1;
            flash_addr   <= '0;
            data_bus_out <= '0;
            data_bus_oe  <= 1'b0;
        end else begin
            flash_ce_n   <= !(state_r == S_READ || state_r == S_RESET);
            flash_oe_n   <= !(state_r == S_READ);
            flash_we_n   <= !(state_r == S_RESET && cnt_r != 16'(STROBE_CYC - 1));
            flash_addr   <= addr_r;
            data_bus_out <= DATA_W'(`FWS_CMD_RESET);
            data_bus_oe  <= state_r == S_RESET;
        end
    end

endmodule

// ==== tb/fws_flash.sv ====
// Behavioural flash that answers the poller's status reads
`timescale 1ns/1ps
module fws_flash (
    // Clock and strobes
    input  wire logic        ref_clk,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    // Bus from the poller
    input  wire logic [15:0] data_bus_out,
    input  wire logic        data_bus_oe,
    // Status back
    output logic      [15:0] data_bus_in,
    output logic             ready_busy_output
);
    int          left = 0;
    logic        ers = 0, w7 = 0, hung = 0, tog = 0, rd_q = 0, rst_seen = 0;
    logic        prot = 0, susp = 0, tog2 = 0;
    logic [15:0] last = 16'h0000, val;
    wire         rd   = !flash_ce_n && !flash_oe_n;
    wire         busy = left > 0 || hung;
    wire         lim  = hung && left == 0; // Limit shows once a failing op runs out
    // Arm one operation; a failing one stays busy until the reset command
    task arm(input logic e, input logic w, input int n, input logic f);
        ers = e;
        w7 = w;
        left = n; // Status shows from the last command write on
        hung = f;
        rst_seen = 0;
        prot = 0;
        susp = 0;
    endtask
    // Protected target: busy for a while, then old contents; suspend: erase held, ready high
    task cond(input logic p, input logic s);
        prot = p;
        susp = s;
    endtask
    // Status while busy or suspended, array data otherwise
    always_comb begin
        if (busy) val = {8'h00, !ers && !w7, tog, lim, 2'b00, ers && tog2, 2'b00};
        else if (susp) val = {8'h00, 1'b1, tog, 3'b000, tog2, 2'b00};
        else if (prot) val = ers ? 16'h5A5A : {8'h3C, !w7, 7'h15};
        else val = ers ? 16'hFFFF : {8'h3C, w7, 7'h15}; // Unprotected sectors erased
    end
    // A released bus shows the inverse of the last value, never a kind constant
    assign data_bus_in = rd ? val : ~last;
    assign ready_busy_output = !busy; // Open drain with pull-up
    // Each new read while busy toggles and counts down; the reset command clears a hang
    always @(posedge ref_clk) begin
        rd_q <= rd;
        if (rd) last <= val;
        if (rd && !rd_q && busy) begin
            tog <= !tog;
            if (left > 0) left <= left - 1;
        end
        if (rd && !rd_q && ers && (busy || susp)) begin
            tog2 <= !tog2; // Selected sector toggles, erasing or suspended
        end
        if (!flash_we_n && data_bus_oe && data_bus_out[7:0] == 8'hF0) begin
            hung <= 0;
            left <= 0;
            rst_seen <= 1;
        end
    end
endmodule

// ==== tb/fws_poller_chk.sv ====
// Protocol checks on the poller's flash strobes
`timescale 1ns/1ps
module fws_poller_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Flash side
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] data_bus_out,
    input wire logic        data_bus_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_strobe;
        !flash_oe_n [*7] ##1 flash_oe_n;
    endsequence
    sequence s_gap;
        flash_oe_n [*3];
    endsequence
    property p_idle_after_reset;
        $rose(rst_n) |-> flash_ce_n && flash_oe_n && flash_we_n && !data_bus_oe;
    endproperty
    property p_read_shape;
        $fell(flash_oe_n) |-> s_strobe ##0 s_gap;
    endproperty
    property p_ce_with_oe;
        !flash_oe_n |-> !flash_ce_n;
    endproperty
    property p_ce_release;
        $rose(flash_oe_n) |-> flash_ce_n;
    endproperty
    property p_addr_held;
        !flash_oe_n |-> $stable(flash_addr);
    endproperty
    property p_reset_word;
        !flash_we_n |-> data_bus_oe && !flash_ce_n && data_bus_out[7:0] == 8'hF0;
    endproperty
    property p_no_clash;
        data_bus_oe |-> flash_oe_n;
    endproperty
    property p_we_release;
        $fell(flash_we_n) |-> ##[1:20] flash_we_n;
    endproperty
    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("strobes active right after reset");
    a_read_shape: assert property (p_read_shape)
        else $error("read strobe or gap has wrong length");
    a_ce_with_oe: assert property (p_ce_with_oe)
        else $error("output strobe without chip select");
    a_ce_release: assert property (p_ce_release)
        else $error("chip select held across reads");
    a_addr_held: assert property (p_addr_held)
        else $error("address moved during a read");
    a_reset_word: assert property (p_reset_word)
        else $error("write strobe without reset command");
    a_no_clash: assert property (p_no_clash)
        else $error("bus driven while reading");
    a_we_release: assert property (p_we_release)
        else $error("write strobe stuck low");
endmodule
bind fws_poller fws_poller_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));

// ==== tb/tb_fws_poller.sv ====
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
`include "fws_defs.svh"
module tb_fws_poller;
    logic        ref_clk = 0, rst_n = 0, reg_we = 0, reg_re = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v, seed = 32'h3587;
    logic        flash_ce_n, flash_oe_n, flash_we_n, data_bus_oe, ready_busy_output;
    logic [21:0] flash_addr;
    logic [15:0] data_bus_in, data_bus_out;
    int          fail_count = 0, tests_run = 0;
    always #5 ref_clk = !ref_clk;
    fws_poller #(.TIMEOUT_CYC(2000)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_addr(flash_addr), .data_bus_in(data_bus_in),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .ready_busy_output(ready_busy_output));
    fws_flash model (.ref_clk(ref_clk), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .data_bus_in(data_bus_in), .ready_busy_output(ready_busy_output));
    function logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Sticky status after an op: ready, timeout flag, fail or done, not busy
    function logic [31:0] exp_st(input logic f, input logic tmo);
        return {27'h0, 1'b1, tmo, f, !f, 1'b0};
    endfunction
    // Array word after an op: erased, programmed, old contents if protected, status in suspend
    function logic [31:0] exp_wd(input logic e, input logic w, input logic p, input logic s);
        if (s) return 32'h0000_0080;
        if (p) return e ? 32'h0000_5A5A : {16'h0, 8'h3C, !w, 7'h15};
        return e ? 32'h0000_FFFF : {16'h0, 8'h3C, w, 7'h15};
    endfunction
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_we <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_we <= 0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_re <= 1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_re <= 0;
        #1 v = reg_rdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One operation: arm the flash, start, wait bounded for busy to clear
    task run(input logic e, input logic t, input logic w, input int n, input logic f,
             input logic p, input logic s);
        int   k;
        logic tmo;
        model.arm(e, w, n, f);
        model.cond(p, s);
        tmo = p && !t; // Protected target never matches in poll mode, so the poller times out
        seed = xs(seed);
        wr(`FWS_REG_ADDR, {10'h000, seed[21:0]});
        wr(`FWS_REG_DATA, {24'h0, w, 7'h15});
        wr(`FWS_REG_CTRL, {29'h0, t, e, 1'b1});
        k = 0;
        do begin
            rd(`FWS_REG_STATUS);
            k++;
        end while (v[0] !== 1'b0 && k < 2000);
        chk(v & 32'h0000_001F, exp_st(f || tmo, tmo));
        chk({31'h0, model.rst_seen}, {31'h0, f || tmo});
        if (!f && !tmo) begin
            rd(`FWS_REG_WORD);
            chk(s ? v & 32'h0000_FFBB : v, exp_wd(e, w, p, s));
        end
        $display("test done erase=%0d toggle=%0d fail=%0d", e, t, f);
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1;
        run(0, 0, 1, 5, 0, 0, 0);
        run(0, 0, 0, 1, 0, 0, 0);
        run(1, 0, 0, 4, 0, 0, 0);
        run(0, 1, 1, 6, 0, 0, 0);
        run(1, 1, 0, 3, 0, 0, 0);
        rd(`FWS_REG_STATUS);
        chk({31'h0, v[`FWS_ST_SECT]}, 32'h0000_0001);
        run(0, 0, 1, 3, 1, 0, 0);
        run(1, 1, 0, 2, 1, 0, 0);
        run(0, 1, 1, 9, 0, 1, 0);
        run(1, 1, 0, 12, 0, 1, 0);
        run(1, 0, 0, 0, 0, 0, 1);
        run(1, 1, 0, 0, 0, 0, 1);
        run(0, 0, 0, 9, 0, 1, 0);
        rd(4'hF);
        chk(v, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            run(seed[0], seed[1], seed[2], 1 + seed[5:3], 0, 0, 0);
        end
        final_report;
    end
endmodule
